/* File: rtl/edge_sense.sv */
`timescale 1ns/1ps
`default_nettype none

// Pin synchroniser and selectable edge detector for one line
module edge_sense
(
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic pin_i,
    input wire logic rise_sel_i,
    input wire logic fall_sel_i,
    output logic hit_o
);

    logic meta;    // First stage, read only by the second
    logic sync;    // Synchronised level
    logic prev;    // Level one cycle earlier

    // Two-stage synchroniser plus history
    always_ff @(posedge mclk_i)
    begin
        if (!rst_n_i)
        begin
            meta <= 1'b0;
            sync <= 1'b0;
            prev <= 1'b0;
        end
        else
        begin
            meta <= pin_i;
            sync <= meta;
            prev <= sync;
        end
    end

    // Both selects clear means no detection at all
    assign hit_o = (sync & ~prev & rise_sel_i)
                 | (~sync & prev & fall_sel_i);

endmodule

`default_nettype wire

/* File: rtl/vectored_interrupt_priority_unit.sv */
// How it works
// - Rise/fall select pair picks detected edge
// - Select bits 0-3 and 5; others zero
// - Reset clears both edge selectors
// - Reset sets in-service bit, gate closed
// - Gate bit set/cleared by ops, writes
// - Eligible when pending set and unblocked
// - Gate needed; low urgency waits on in-service
// - Urgent service 7 to 32 clocks
// - Relaxed service 8 to 33 clocks
// - Urgency first, then default priority
// - Untaken requests stay pending
// - Ack pushes status, PC; loads vector
// - Returns and pop restore status word
// - Trap always taken, fixed vector
// - Nest equal or higher urgency only
// - Nesting table per in-service and trap
// - Urgency 0 is the higher level
// - In-service bit 0 during urgent service
// - One program instruction after return
// - Ack clears the source pending bit
// - Hold instructions defer one instruction
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module vectored_interrupt_priority_unit
    import vip_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // Register port
    input wire logic [15:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    // Request sources
    input wire logic [EXT_LINES-1:0] ext_irq_line_i,
    input wire logic [SOURCES-1:0] periph_req_i,
    // Core sequencer
    input wire core_ops_t ops_i,
    input wire logic [7:0] restore_data_i,
    input wire logic status_bit_wr_i,
    input wire logic [2:0] status_bit_idx_i,
    input wire logic status_bit_val_i,
    input wire logic [15:0] pc_i,
    output stack_wr_t stack_o,
    output logic vector_load_o,
    output logic [15:0] vector_addr_o,
    output logic busy_o,
    output logic [7:0] status_word_o
);

    logic [7:0] rise_edge_select;     // Rising edge enables
    logic [7:0] fall_edge_select;     // Falling edge enables
    logic [7:0] status_word;          // Gate and in-service bits live here
    logic [SOURCES-1:0] pending;      // Request pending bits
    logic [SOURCES-1:0] req_block;    // Request block bits
    logic [SOURCES-1:0] urgency;      // Urgency bits, 0 is urgent
    logic [EXT_LINES-1:0] ext_hit;    // Selected edge seen this cycle
    logic [SOURCES-1:0] set_req;      // All request events
    logic [SOURCES-1:0] next_pending; // Pending bits before new events
    logic in_trap;                    // Inside a software trap handler
    seq_state_t state;                // Service sequencer
    seq_state_t next_state;
    logic [15:0] next_vector;         // Vector chosen at acknowledge
    logic [15:0] saved_pc;            // Return address to push
    logic [7:0] saved_status;         // Status to push
    logic [2:0] wait_cnt;             // Clocks the winner has waited
    logic [SRC_W-1:0] last_win;       // Winner in the previous cycle
    logic win_valid;                  // A request can be taken
    logic [SRC_W-1:0] win_idx;        // Index of that request
    logic win_urg;                    // Its urgency bit
    logic ack;                        // Maskable acknowledge now
    logic trap_ack;                   // Software trap taken now
    logic boundary_ok;                // Boundary where ack is allowed
    logic gate;
    logic in_service;

    assign gate = status_word[GATE_BIT];
    assign in_service = status_word[IN_SERVICE_BIT];

    // One detector per external line; line 4 has no pin function
    genvar g;
    generate
        for (g = 0; g < EXT_LINES; g++)
        begin : g_ext
            edge_sense u_edge
            (
                .mclk_i(mclk_i),
                .rst_n_i(rst_n_i),
                .pin_i(ext_irq_line_i[g]),
                .rise_sel_i(rise_edge_select[g]),
                .fall_sel_i(fall_edge_select[g]),
                .hit_o(ext_hit[g])
            );
        end
    endgenerate

    // External line n feeds source n; peripherals feed any source
    assign set_req = periph_req_i
                   | {{(SOURCES-EXT_LINES){1'b0}}, ext_hit};

    // Edge selectors; unimplemented bits can never be written
    always_ff @(posedge mclk_i)
    begin
        if (!rst_n_i)
        begin
            rise_edge_select <= EDGE_SELECT_RESET;
            fall_edge_select <= EDGE_SELECT_RESET;
        end
        else if (wr_i && addr_i == RISE_EDGE_SELECT_ADDR)
            rise_edge_select <= wdata_i & EDGE_SELECT_MASK;
        else if (wr_i && addr_i == FALL_EDGE_SELECT_ADDR)
            fall_edge_select <= wdata_i & EDGE_SELECT_MASK;
    end

    // Winner search: urgent level first, then lowest index
    always_comb
    begin
        logic found;
        logic allow_relaxed;
        found = 1'b0;
        allow_relaxed = in_service | in_trap;
        win_idx = '0;
        win_urg = 1'b0;
        for (int i = SOURCES - 1; i >= 0; i--)
        begin
            // Eligible only when pending and not blocked
            if (pending[i] && !req_block[i] && !urgency[i])
            begin
                found = 1'b1;
                win_idx = SRC_W'(i);
                win_urg = 1'b0;
            end
        end
        // Relaxed requests only when nothing urgent waits
        if (!found && allow_relaxed)
        begin
            for (int i = SOURCES - 1; i >= 0; i--)
            begin
                if (pending[i] && !req_block[i] && urgency[i])
                begin
                    found = 1'b1;
                    win_idx = SRC_W'(i);
                    win_urg = 1'b1;
                end
            end
        end
        win_valid = found;
    end

    // Age of the current winner, restarted when the winner changes
    always_ff @(posedge mclk_i)
    begin
        if (!rst_n_i)
        begin
            wait_cnt <= '0;
            last_win <= '0;
        end
        else
        begin
            last_win <= win_idx;
            if (!win_valid || win_idx != last_win)
                wait_cnt <= '0;
            else if (wait_cnt != 3'h7)
                wait_cnt <= wait_cnt + 3'h1;
        end
    end

    // A hold instruction's own boundary never acknowledges
    assign boundary_ok = ops_i.done && state == SEQ_IDLE
                       && !ops_i.hold && !ops_i.gate_open
                       && !ops_i.gate_close && !ops_i.irq_return
                       && !ops_i.trap_return
                       && !ops_i.status_pop;
    assign trap_ack = ops_i.done && ops_i.soft_trap
                    && state == SEQ_IDLE;
    // Minimum wait keeps the latency floor
    assign ack = boundary_ok && !ops_i.soft_trap && gate && win_valid
               && wait_cnt >= (win_urg ? PRE_WAIT_RELAXED
                                       : PRE_WAIT_URGENT);

    // Pending bits after software writes and the acknowledge clear
    always_comb
    begin
        next_pending = pending;
        if (wr_i && addr_i == PENDING_LO_ADDR)
            next_pending[7:0] = wdata_i;
        if (wr_i && addr_i == PENDING_HI_ADDR)
            next_pending[15:8] = wdata_i;
        if (ack)
            next_pending[win_idx] = 1'b0;
    end

    // A new event beats any clear in the same cycle
    always_ff @(posedge mclk_i)
    begin
        if (!rst_n_i)
            pending <= '0;
        else
            pending <= next_pending | set_req;
    end

    // Block and urgency bytes, written whole by software
    always_ff @(posedge mclk_i)
    begin
        if (!rst_n_i)
        begin
            req_block <= BLOCK_RESET;
            urgency <= URGENCY_RESET;
        end
        else if (wr_i)
        begin
            unique case (addr_i)
                BLOCK_LO_ADDR: req_block[7:0] <= wdata_i;
                BLOCK_HI_ADDR: req_block[15:8] <= wdata_i;
                URGENCY_LO_ADDR: urgency[7:0] <= wdata_i;
                URGENCY_HI_ADDR: urgency[15:8] <= wdata_i;
                default: ;
            endcase
        end
    end

    // Status word: acknowledge has the last say in its cycle
    always_ff @(posedge mclk_i)
    begin
        if (!rst_n_i)
            status_word <= STATUS_WORD_RESET;
        else if (ack)
        begin
            status_word[GATE_BIT] <= 1'b0;
            status_word[IN_SERVICE_BIT] <= win_urg;
        end
        else if (trap_ack)
            status_word[GATE_BIT] <= 1'b0;
        else if (ops_i.done && (ops_i.irq_return || ops_i.trap_return
                                || ops_i.status_pop))
            status_word <= restore_data_i;
        else if (ops_i.done && ops_i.gate_open)
            status_word[GATE_BIT] <= 1'b1;
        else if (ops_i.done && ops_i.gate_close)
            status_word[GATE_BIT] <= 1'b0;
        else if (status_bit_wr_i)
            status_word[status_bit_idx_i] <= status_bit_val_i;
        else if (wr_i && addr_i == STATUS_WORD_ADDR)
            status_word <= wdata_i;
    end

    // Trap context; a single level, the handler leaves by trap return
    always_ff @(posedge mclk_i)
    begin
        if (!rst_n_i)
            in_trap <= 1'b0;
        else if (trap_ack)
            in_trap <= 1'b1;
        else if (ops_i.done && ops_i.trap_return)
            in_trap <= 1'b0;
    end

    // Capture what the sequence pushes and where it jumps
    always_ff @(posedge mclk_i)
    begin
        if (!rst_n_i)
        begin
            saved_pc <= '0;
            saved_status <= '0;
            next_vector <= '0;
        end
        else if (ack || trap_ack)
        begin
            saved_pc <= pc_i;
            saved_status <= status_word;
            next_vector <= trap_ack ? TRAP_VECTOR
                         : VECTOR_BASE + {11'h000, win_idx, 1'b0};
        end
    end

    // Sequencer: status, PC high, PC low, then vector
    always_comb
    begin
        next_state = state;
        unique case (state)
            SEQ_IDLE:
                if (ack || trap_ack)
                    next_state = SEQ_PUSH_STATUS;
            SEQ_PUSH_STATUS: next_state = SEQ_PUSH_PC_HI;
            SEQ_PUSH_PC_HI: next_state = SEQ_PUSH_PC_LO;
            SEQ_PUSH_PC_LO: next_state = SEQ_LOAD_VECTOR;
            SEQ_LOAD_VECTOR: next_state = SEQ_IDLE;
        endcase
    end

    // State register
    always_ff @(posedge mclk_i)
    begin
        if (!rst_n_i)
            state <= SEQ_IDLE;
        else
            state <= next_state;
    end

    // Stack and vector outputs, registered from the current state
    always_ff @(posedge mclk_i)
    begin
        if (!rst_n_i)
        begin
            stack_o <= '0;
            vector_load_o <= 1'b0;
            vector_addr_o <= '0;
        end
        else
        begin
            stack_o.push <= 1'b0;
            vector_load_o <= 1'b0;
            unique case (state)
                SEQ_PUSH_STATUS:
                begin
                    stack_o.push <= 1'b1;
                    stack_o.data <= saved_status;
                end
                SEQ_PUSH_PC_HI:
                begin
                    stack_o.push <= 1'b1;
                    stack_o.data <= saved_pc[15:8];
                end
                SEQ_PUSH_PC_LO:
                begin
                    stack_o.push <= 1'b1;
                    stack_o.data <= saved_pc[7:0];
                end
                default: ;
            endcase
            // Jump only once the whole frame is on the stack
            if (state == SEQ_LOAD_VECTOR)
            begin
                vector_load_o <= 1'b1;
                vector_addr_o <= next_vector;
            end
        end
    end

    // Core stalls while the sequence runs
    assign busy_o = state != SEQ_IDLE;
    // Status push instruction stores this value
    assign status_word_o = status_word;

    // Read data, one cycle after the strobe, zero when unmapped
    always_ff @(posedge mclk_i)
    begin
        if (!rst_n_i)
            rdata_o <= '0;
        else if (rd_i)
        begin
            unique case (addr_i)
                RISE_EDGE_SELECT_ADDR: rdata_o <= rise_edge_select;
                FALL_EDGE_SELECT_ADDR: rdata_o <= fall_edge_select;
                STATUS_WORD_ADDR: rdata_o <= status_word;
                PENDING_LO_ADDR: rdata_o <= pending[7:0];
                PENDING_HI_ADDR: rdata_o <= pending[15:8];
                BLOCK_LO_ADDR: rdata_o <= req_block[7:0];
                BLOCK_HI_ADDR: rdata_o <= req_block[15:8];
                URGENCY_LO_ADDR: rdata_o <= urgency[7:0];
                URGENCY_HI_ADDR: rdata_o <= urgency[15:8];
                default: rdata_o <= '0;
            endcase
        end
    end

    chk_edge_reserved_zero: assert property (
        @(posedge mclk_i) disable iff (!rst_n_i)
        ((rise_edge_select | fall_edge_select) & ~EDGE_SELECT_MASK) == 8'h00)
        else $error("edge select reserved bit set");

    chk_reset_status_value: assert property (
        @(posedge mclk_i) !rst_n_i |=> status_word == STATUS_WORD_RESET)
        else $error("status word wrong after reset");

    chk_ack_needs_gate: assert property (
        @(posedge mclk_i) disable iff (!rst_n_i)
        ack |-> gate && (!win_urg || in_service || in_trap))
        else $error("acknowledge without permission");

    chk_ack_closes_gate: assert property (
        @(posedge mclk_i) disable iff (!rst_n_i)
        ack |=> !gate && in_service == $past(win_urg))
        else $error("acknowledge did not update status");

    chk_trap_vector_load: assert property (
        @(posedge mclk_i) disable iff (!rst_n_i)
        trap_ack |-> ##5 vector_load_o && vector_addr_o == TRAP_VECTOR)
        else $error("trap vector not loaded");

    chk_hold_defers_ack: assert property (
        @(posedge mclk_i) disable iff (!rst_n_i)
        ops_i.done && (ops_i.hold || ops_i.gate_open) |-> !ack)
        else $error("acknowledge on hold boundary");

    chk_min_wait_floor: assert property (
        @(posedge mclk_i) disable iff (!rst_n_i)
        ack && !win_urg |-> $past(win_valid, 3) && wait_cnt >= 3'h3)
        else $error("urgent request taken too early");

    chk_ack_clears_pending: assert property (
        @(posedge mclk_i) disable iff (!rst_n_i)
        ack && !set_req[win_idx] |=> !pending[$past(win_idx)])
        else $error("pending bit kept after acknowledge");

    chk_push_sequence: assert property (
        @(posedge mclk_i) disable iff (!rst_n_i)
        ack |-> ##2 stack_o.push [*3] ##1 vector_load_o && !stack_o.push)
        else $error("push sequence broken");

endmodule

`default_nettype wire

/* File: rtl/vip_pkg.sv */
package vip_pkg;

    // Register map of the edge selectors
    localparam logic [15:0] RISE_EDGE_SELECT_ADDR = 16'hFF48;
    localparam logic [15:0] FALL_EDGE_SELECT_ADDR = 16'hFF49;
    // Status word and request flag bytes
    localparam logic [15:0] STATUS_WORD_ADDR = 16'hFF1E;
    localparam logic [15:0] PENDING_LO_ADDR = 16'hFFE0;
    localparam logic [15:0] PENDING_HI_ADDR = 16'hFFE1;
    localparam logic [15:0] BLOCK_LO_ADDR = 16'hFFE4;
    localparam logic [15:0] BLOCK_HI_ADDR = 16'hFFE5;
    localparam logic [15:0] URGENCY_LO_ADDR = 16'hFFE8;
    localparam logic [15:0] URGENCY_HI_ADDR = 16'hFFE9;

    // Edge selector implemented bits: inputs 0 to 3 and 5
    localparam logic [7:0] EDGE_SELECT_MASK = 8'h2F;
    localparam logic [7:0] EDGE_SELECT_RESET = 8'h00;
    localparam int EXT_LINES = 6;

    // Status word layout and reset
    localparam logic [7:0] STATUS_WORD_RESET = 8'h02;
    localparam int GATE_BIT = 7;
    localparam int IN_SERVICE_BIT = 1;

    // Request sources; index is the fixed default priority, 0 highest
    localparam int SOURCES = 16;
    localparam int SRC_W = 4;
    localparam logic [15:0] BLOCK_RESET = 16'hFFFF;
    localparam logic [15:0] URGENCY_RESET = 16'hFFFF;

    // Vector table: two bytes per source from this base
    localparam logic [15:0] VECTOR_BASE = 16'h0004;
    localparam logic [15:0] TRAP_VECTOR = 16'h003E;

    // Acknowledge latency in CPU clocks, request to vector load
    localparam int MIN_CLK_URGENT = 7;
    localparam int MIN_CLK_RELAXED = 8;
    localparam int MAX_CLK_URGENT = 32;
    localparam int MAX_CLK_RELAXED = 33;
    localparam int SEQ_CYCLES = 4;
    localparam logic [2:0] PRE_WAIT_URGENT = 3'(MIN_CLK_URGENT - SEQ_CYCLES);
    localparam logic [2:0] PRE_WAIT_RELAXED =
        3'(MIN_CLK_RELAXED - SEQ_CYCLES);

    // Service sequencer states
    typedef enum logic [2:0] {
        SEQ_IDLE,
        SEQ_PUSH_STATUS,
        SEQ_PUSH_PC_HI,
        SEQ_PUSH_PC_LO,
        SEQ_LOAD_VECTOR
    } seq_state_t;

    // Instruction events from the core, valid with done
    typedef struct packed {
        logic done;         // An instruction completes this cycle
        logic hold;         // It touches status or request flag bytes
        logic gate_open;    // Enable instruction
        logic gate_close;   // Disable instruction
        logic soft_trap;    // Software trap instruction
        logic irq_return;   // Interrupt return instruction
        logic trap_return;  // Trap return instruction
        logic status_pop;   // Status pop instruction
    } core_ops_t;

    // Stack write towards the core
    typedef struct packed {
        logic push;
        logic [7:0] data;
    } stack_wr_t;

endpackage

/* File: verif/core_model.sv */
`timescale 1ns/1ps
`default_nettype none

// Behavioural core sequencer: retires one instruction per free cycle, or on every other cycle when slow
module core_model
    import vip_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic slow_i,
    input wire logic cmd_v_i,
    input wire core_ops_t cmd_i,
    input wire logic busy_i,
    input wire stack_wr_t stack_i,
    input wire logic vector_load_i,
    output core_ops_t ops_o,
    output logic [15:0] pc_o
);
    logic tick; // Alternates to pace a slow core
    logic done; // An instruction retires this cycle
    core_ops_t held; // Special instruction waiting to retire
    logic [7:0] q[$]; // Bytes pushed onto the stack
    int nvec = 0; // Vector loads seen so far

    // Never retire while the unit stalls us, nor in reset
    assign done = rst_n_i & ~busy_i & (tick | ~slow_i);
    assign ops_o = done ? (held | core_ops_t'(8'h80)) : '0;

    // Pace, pending special op and return address
    always_ff @(posedge mclk_i)
    begin
        if (!rst_n_i)
        begin
            tick <= 1'b0;
            held <= '0;
            pc_o <= 16'h1234;
        end
        else
        begin
            tick <= ~tick;
            // A new command wins over retiring the old one
            if (cmd_v_i)
                held <= cmd_i;
            else if (done)
                held <= '0;
            if (done)
                pc_o <= pc_o + 16'h0001;
        end
    end

    // Keep stack traffic for the bench to inspect
    always @(posedge mclk_i)
    begin
        if (stack_i.push)
            q.push_back(stack_i.data);
        if (vector_load_i)
            nvec++;
    end
endmodule
`default_nettype wire

/* File: verif/vectored_interrupt_priority_unit_test.sv */
`timescale 1ns/1ps
`default_nettype none

module vectored_interrupt_priority_unit_test;
    import vip_pkg::*;
    logic mclk_i = 1'b0; // CPU clock
    logic rst_n_i = 1'b0; // Synchronous reset
    logic [15:0] addr = 16'h0000; // Register address
    logic [7:0] wdata = 8'h00; // Write data
    logic wr_s = 1'b0; // Write strobe
    logic rd_s = 1'b0; // Read strobe
    logic [7:0] rdata; // Read data
    logic [5:0] pins = 6'h00; // External lines
    logic [15:0] preq = 16'h0000; // Peripheral requests
    logic [7:0] restore = 8'h82; // Status popped by core
    logic sbw = 1'b0; // Status bit write
    logic [2:0] sbi = 3'h0; // Status bit index
    logic sbv = 1'b0; // Status bit value
    logic slow = 1'b0; // Core pace
    logic cmd_v = 1'b0; // Special op strobe
    core_ops_t cmd = '0; // Special op
    core_ops_t ops; // Ops to the unit
    logic [15:0] pc; // Return address
    stack_wr_t stk; // Stack writes
    logic vload; // Vector load pulse
    logic [15:0] vaddr; // Vector address
    logic busy; // Sequence running
    logic [7:0] sw; // Status word
    int failures = 0;
    int tests_run = 0;
    int n; // Latency in clocks
    int k; // Vector loads before a wait

    vectored_interrupt_priority_unit dut_u (.mclk_i(mclk_i),
        .rst_n_i(rst_n_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr_s),
        .rd_i(rd_s), .rdata_o(rdata), .ext_irq_line_i(pins),
        .periph_req_i(preq), .ops_i(ops), .restore_data_i(restore),
        .status_bit_wr_i(sbw), .status_bit_idx_i(sbi),
        .status_bit_val_i(sbv), .pc_i(pc), .stack_o(stk),
        .vector_load_o(vload), .vector_addr_o(vaddr), .busy_o(busy),
        .status_word_o(sw));

    core_model core_u (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .slow_i(slow),
        .cmd_v_i(cmd_v), .cmd_i(cmd), .busy_i(busy), .stack_i(stk),
        .vector_load_i(vload), .ops_o(ops), .pc_o(pc));

    // 100 ns clock
    initial
    begin
        forever #50 mclk_i = ~mclk_i;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            failures++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_n(input int v, input int lo, input int hi);
        tests_run++;
        if (v < lo || v > hi)
        begin
            failures++;
            $display("ERROR %0t: latency %0d out of range", $time, v);
        end
    endtask

    // One-cycle write; result visible right after
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge mclk_i);
        wr_s <= 1'b0;
        #1;
    endtask

    // Read data appears the cycle after the strobe and holds until the next read
    task automatic chk_rd(input logic [15:0] a, input logic [7:0] e);
        @(posedge mclk_i);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge mclk_i);
        rd_s <= 1'b0;
        #1;
        chk(rdata, e);
    endtask

    // Hand a special instruction to the core, let it retire
    task automatic op(input logic [7:0] c);
        @(posedge mclk_i);
        cmd <= core_ops_t'(c);
        cmd_v <= 1'b1;
        @(posedge mclk_i);
        cmd_v <= 1'b0;
        repeat (3) @(posedge mclk_i);
        #1;
    endtask

    // Bounded wait for the vector load, then check its address
    task automatic wv(input logic [15:0] e, output int c);
        c = 0;
        while (vload !== 1'b1 && c < 60)
        begin
            @(posedge mclk_i);
            #1;
            c++;
        end
        chk(vaddr, e);
    endtask

    // Walk line 5 through all four select codes
    task automatic t_edges();
        for (int m = 0; m < 4; m++)
        begin
            wr(RISE_EDGE_SELECT_ADDR, m[1] ? 8'h20 : 8'h00);
            wr(FALL_EDGE_SELECT_ADDR, m[0] ? 8'h20 : 8'h00);
            wr(PENDING_LO_ADDR, 8'h00);
            @(posedge mclk_i);
            pins[5] <= 1'b1;
            repeat (6) @(posedge mclk_i);
            chk_rd(PENDING_LO_ADDR, m[1] ? 8'h20 : 8'h00);
            wr(PENDING_LO_ADDR, 8'h00);
            @(posedge mclk_i);
            pins[5] <= 1'b0;
            repeat (6) @(posedge mclk_i);
            chk_rd(PENDING_LO_ADDR, m[0] ? 8'h20 : 8'h00);
        end
        wr(RISE_EDGE_SELECT_ADDR, 8'h00);
        wr(FALL_EDGE_SELECT_ADDR, 8'h00);
        wr(PENDING_LO_ADDR, 8'h00);
    endtask

    // Source 3 at both urgencies, prompt then slow core
    task automatic t_latency();
        wr(BLOCK_LO_ADDR, 8'hF7);
        for (int u = 0; u < 2; u++)
        begin
            wr(URGENCY_LO_ADDR, u ? 8'hFF : 8'hF7);
            slow <= u[0];
            op(8'h20);
            chk(sw[GATE_BIT], 1'b1);
            @(posedge mclk_i);
            preq <= 16'h0008;
            @(posedge mclk_i);
            preq <= 16'h0000;
            wv(VECTOR_BASE + 16'h0006, n);
            if (u == 0)
                chk_n(n, MIN_CLK_URGENT, MAX_CLK_URGENT);
            else
                chk_n(n, MIN_CLK_RELAXED, MAX_CLK_RELAXED);
            chk(sw, u ? 8'h02 : 8'h00);
            chk(core_u.q[$-2], 8'h82);
            chk_rd(PENDING_LO_ADDR, 8'h00);
            op(8'h04);
            chk(sw, 8'h82);
        end
        slow <= 1'b0;
    endtask

    // Two requests at once; the urgent one nests the other out
    task automatic t_priority();
        op(8'h10);
        wr(BLOCK_LO_ADDR, 8'hDB);
        wr(URGENCY_LO_ADDR, 8'hDF);
        @(posedge mclk_i);
        preq <= 16'h0024;
        @(posedge mclk_i);
        preq <= 16'h0000;
        repeat (10) @(posedge mclk_i);
        chk_rd(PENDING_LO_ADDR, 8'h24);
        op(8'h20);
        wv(VECTOR_BASE + 16'h000A, n);
        chk(sw, 8'h00);
        op(8'h20);
        k = core_u.nvec;
        repeat (40) @(posedge mclk_i);
        chk(16'(core_u.nvec), 16'(k));
        op(8'h04);
        wv(VECTOR_BASE + 16'h0004, n);
        chk(sw, 8'h02);
        op(8'h04);
    endtask

    // Trap is taken even with the gate closed
    task automatic t_trap();
        op(8'h10);
        k = core_u.q.size();
        op(8'h08);
        wv(TRAP_VECTOR, n);
        chk(sw[GATE_BIT], 1'b0);
        chk(16'(core_u.q.size() - k), 16'h0003);
        chk(core_u.q[$-2], 8'h02);
        chk({core_u.q[$-1], core_u.q[$]}, pc - 16'h0001);
        chk(busy, 1'b0);
        op(8'h02);
        chk(sw, 8'h82);
    endtask

    // Bit, byte and dedicated-op access to the gate
    task automatic t_status();
        @(posedge mclk_i);
        sbw <= 1'b1;
        sbi <= 3'h7;
        sbv <= 1'b0;
        @(posedge mclk_i);
        sbw <= 1'b0;
        #1;
        chk(sw, 8'h02);
        wr(STATUS_WORD_ADDR, 8'h80);
        chk_rd(STATUS_WORD_ADDR, 8'h80);
        op(8'h10);
        chk(sw, 8'h00);
        op(8'h01);
        chk(sw, 8'h82);
    endtask

    task automatic end_of_test();
        $display("tests_run=%0d failures=%0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Whole run is a few hundred clocks; this cuts a hang
    initial
    begin
        repeat (20000) @(posedge mclk_i);
        failures++;
        end_of_test();
    end

    // Main sequence
    initial
    begin
        repeat (5) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        @(posedge mclk_i);
        #1;
        chk(sw, STATUS_WORD_RESET);
        chk_rd(RISE_EDGE_SELECT_ADDR, EDGE_SELECT_RESET);
        chk_rd(FALL_EDGE_SELECT_ADDR, EDGE_SELECT_RESET);
        chk_rd(16'hFF00, 8'h00);
        wr(RISE_EDGE_SELECT_ADDR, 8'hFF);
        chk_rd(RISE_EDGE_SELECT_ADDR, EDGE_SELECT_MASK);
        wr(FALL_EDGE_SELECT_ADDR, 8'hFF);
        chk_rd(FALL_EDGE_SELECT_ADDR, EDGE_SELECT_MASK);
        t_edges();
        t_latency();
        t_priority();
        t_trap();
        t_status();
        end_of_test();
    end
endmodule
`default_nettype wire
